// ### lpv_pkg.sv
`default_nettype none
package lpv_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] LPV_OFS_LINK_STATUS = 8'hc0;
	localparam logic [7:0] LPV_OFS_PHY_CFG0    = 8'hcc;
	localparam logic [7:0] LPV_OFS_PHY_CFG1    = 8'hd0;
	localparam logic [7:0] LPV_OFS_PHY_CFG2    = 8'hd4;
	localparam logic [7:0] LPV_OFS_PD_CTRL     = 8'hd8;
	localparam logic [7:0] LPV_OFS_PD_DATA     = 8'hec;
	localparam logic [7:0] LPV_OFS_IRQ_STAT    = 8'hf8;
	localparam logic [7:0] LPV_OFS_IRQ_MASK    = 8'hfc;

	// ------------------------------------------------------------
	// field positions and fixed values
	// ------------------------------------------------------------
	localparam int LPV_LS_SPEED_LSB  = 16;
	localparam int LPV_LS_WIDTH_LSB  = 20;
	localparam int LPV_LS_TERR_BIT   = 26;
	localparam int LPV_LS_TRAIN_BIT  = 27;
	localparam int LPV_LS_SLOT_BIT   = 28;
	localparam int LPV_LS_DLL_BIT    = 29;
	localparam int LPV_PD_ADDR_LSB   = 18;
	localparam int LPV_PD_ADDR_W     = 6;
	localparam int LPV_PD_OP_BIT     = 31;
	localparam int LPV_EV_RD_BIT     = 0;
	localparam int LPV_EV_WR_BIT     = 1;
	localparam int LPV_EV_W          = 2;
	localparam logic [7:0] LPV_PD_CAP_ID    = 8'h03;
	localparam logic [7:0] LPV_PD_NEXT_PTR  = 8'hf0;
	localparam logic [7:0] LPV_EE_BASE      = 8'h40;
	localparam logic       LPV_SLOT_CLK_CFG = 1'h1;

	// ------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [31:0] LPV_CFG0_RST  = 32'h0400_1060;
	localparam logic [31:0] LPV_CFG1_RST  = 32'h0400_0800;
	localparam logic [31:0] LPV_CFG2_RST  = 32'h0099_8254;
	localparam logic [31:0] LPV_CFG2_MASK = 32'h00ff_ffff;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] speed;
		logic [5:0] width;
		logic       train_err;
		logic       training;
		logic       dl_inactive;
	} lpv_link_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} lpv_ee_req_s;

	typedef struct packed {
		logic        done;
		logic [31:0] rdata;
	} lpv_ee_rsp_s;

	typedef struct packed {
		logic [31:0] cfg0;
		logic [31:0] cfg1;
		logic [23:0] cfg2;
	} lpv_phy_s;

	typedef enum logic {LPV_OP_READ, LPV_OP_WRITE} lpv_op_e;
endpackage
`default_nettype wire

// ### lpv_regs.sv
// Contract
// - link speed reads at link status bits 19:16, 001 means 2.5 Gb/s.
// - link status bit 29 reads 0 when data link active, 1 otherwise.
// - writing flag 0 starts EEPROM read; flag stays 0, then becomes 1.
// - writing flag 1 starts EEPROM write; flag stays 1, then becomes 0.
// - EEPROM word address comes from bits 23:18; bits 17:16, 30:24 read zero.
// - fetched read data lands in the product-data data register for software.
// - capability header low byte reads 03h, read-only.
// - capability header bits 15:8 read F0h, read-only, next capability.
// - recovery time in fast-training sets held in bits 7:0, reset 54h.
// - power-down wait control bit 23 resets to 1.
// - data low byte maps to EEPROM byte at address plus 0x40.
`timescale 1ns/1ps
`default_nettype none
module lpv_regs (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	// ahb-lite slave
	input  wire logic                 i_hsel,
	input  wire logic [7:0]           i_haddr,
	input  wire logic [1:0]           i_htrans,
	input  wire logic                 i_hwrite,
	input  wire logic [2:0]           i_hsize,
	input  wire logic [31:0]          i_hwdata,
	input  wire logic                 i_hready,
	output logic                      o_hreadyout,
	output logic                      o_hresp,
	output logic [31:0]               o_hrdata,
	// link state from training logic
	input  wire lpv_pkg::lpv_link_s   i_link,
	// tuning values to training logic
	output lpv_pkg::lpv_phy_s         o_phy,
	// eeprom cycle engine
	output lpv_pkg::lpv_ee_req_s      o_ee,
	input  wire lpv_pkg::lpv_ee_rsp_s i_ee,
	output logic                      o_irq
);
	import lpv_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0]            cfg0_r;
	logic [31:0]            cfg1_r;
	logic [31:0]            cfg2_r;
	logic [LPV_PD_ADDR_W-1:0] pd_addr_r;
	lpv_op_e                pd_op_r;
	logic                   busy_r;
	logic [31:0]            pd_data_r;
	logic [LPV_EV_W-1:0]    ev_r;
	logic [LPV_EV_W-1:0]    mask_r;
	logic                   wr_pend_r;
	logic                   rd_pend_r;
	logic [7:0]             addr_r;
	logic                   ready_r;
	logic [31:0]            hrdata_r;

	// ------------------------------------------------------------
	// bus address phase decode
	// ------------------------------------------------------------
	wire addr_ok = i_hsel & i_htrans[1] & i_hready;
	wire rd_take = addr_ok & ~i_hwrite;
	wire wr_take = addr_ok & i_hwrite;

	// data phase write strobes per register
	wire wr_cfg0 = wr_pend_r & (addr_r == LPV_OFS_PHY_CFG0);
	wire wr_cfg1 = wr_pend_r & (addr_r == LPV_OFS_PHY_CFG1);
	wire wr_cfg2 = wr_pend_r & (addr_r == LPV_OFS_PHY_CFG2);
	wire wr_ctrl = wr_pend_r & (addr_r == LPV_OFS_PD_CTRL);
	wire wr_data = wr_pend_r & (addr_r == LPV_OFS_PD_DATA);
	wire wr_stat = wr_pend_r & (addr_r == LPV_OFS_IRQ_STAT);
	wire wr_mask = wr_pend_r & (addr_r == LPV_OFS_IRQ_MASK);

	// ------------------------------------------------------------
	// product-data cycle control
	// ------------------------------------------------------------
	// a new cycle only starts from idle; writes while busy are dropped
	wire start   = wr_ctrl & ~busy_r;
	wire done    = busy_r & i_ee.done;
	wire rd_done = done & (pd_op_r == LPV_OP_READ);
	wire wr_done = done & (pd_op_r == LPV_OP_WRITE);

	// completion events; set wins over a write-one clear
	wire [LPV_EV_W-1:0] ev_set = {wr_done, rd_done};
	wire [LPV_EV_W-1:0] ev_clr = wr_stat ? i_hwdata[LPV_EV_W-1:0] : '0;
	wire [LPV_EV_W-1:0] ev_nxt = (ev_r & ~ev_clr) | ev_set;

	// ------------------------------------------------------------
	// read views
	// ------------------------------------------------------------
	wire [31:0] ls_word = {
		2'h0,
		i_link.dl_inactive,
		LPV_SLOT_CLK_CFG,
		i_link.training,
		i_link.train_err,
		i_link.width,
		i_link.speed,
		16'h0
	};

	// flag reads the op while busy and its complement once done
	wire op_flag = busy_r ? (pd_op_r == LPV_OP_WRITE)
	                      : (pd_op_r == LPV_OP_READ);

	wire [31:0] ctrl_word = {
		op_flag,
		7'h0,
		pd_addr_r,
		2'h0,
		LPV_PD_NEXT_PTR,
		LPV_PD_CAP_ID
	};

	// read mux on the registered data phase address
	logic [31:0] rd_mux;
	always_comb begin
		unique case (addr_r)
			LPV_OFS_LINK_STATUS: rd_mux = ls_word;
			LPV_OFS_PHY_CFG0:    rd_mux = cfg0_r;
			LPV_OFS_PHY_CFG1:    rd_mux = cfg1_r;
			LPV_OFS_PHY_CFG2:    rd_mux = cfg2_r;
			LPV_OFS_PD_CTRL:     rd_mux = ctrl_word;
			LPV_OFS_PD_DATA:     rd_mux = pd_data_r;
			LPV_OFS_IRQ_STAT:    rd_mux = {30'h0, ev_r};
			LPV_OFS_IRQ_MASK:    rd_mux = {30'h0, mask_r};
			default:             rd_mux = 32'h0;
		endcase
	end

	// ------------------------------------------------------------
	// bus transfer tracking
	// ------------------------------------------------------------
	// reads take one wait state so the data come from flip-flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h0;
			ready_r   <= 1'b1;
		end else begin
			wr_pend_r <= wr_take;
			rd_pend_r <= rd_take;
			ready_r   <= ~rd_take;
			if (addr_ok)
				addr_r <= {i_haddr[7:2], 2'h0};
		end
	end

	// capture read data during the wait state
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			hrdata_r <= 32'h0;
		else if (rd_pend_r)
			hrdata_r <= rd_mux;
	end

	// ------------------------------------------------------------
	// phy tuning registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg0_r <= LPV_CFG0_RST;
			cfg1_r <= LPV_CFG1_RST;
			cfg2_r <= LPV_CFG2_RST;
		end else begin
			if (wr_cfg0)
				cfg0_r <= i_hwdata;
			if (wr_cfg1)
				cfg1_r <= i_hwdata;
			if (wr_cfg2)
				cfg2_r <= i_hwdata & LPV_CFG2_MASK;
		end
	end

	// ------------------------------------------------------------
	// product-data address, op and data
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pd_addr_r <= '0;
			pd_op_r   <= LPV_OP_WRITE;
			busy_r    <= 1'b0;
		end else if (start) begin
			pd_addr_r <= i_hwdata[LPV_PD_ADDR_LSB +: LPV_PD_ADDR_W];
			pd_op_r   <= lpv_op_e'(i_hwdata[LPV_PD_OP_BIT]);
			busy_r    <= 1'b1;
		end else if (done) begin
			busy_r    <= 1'b0;
		end
	end

	// read completion loads fetched data; software may stage write data
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			pd_data_r <= 32'h0;
		else if (rd_done)
			pd_data_r <= i_ee.rdata;
		else if (wr_data && !busy_r)
			pd_data_r <= i_hwdata;
	end

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ev_r   <= '0;
			mask_r <= '0;
		end else begin
			ev_r <= ev_nxt;
			if (wr_mask)
				mask_r <= i_hwdata[LPV_EV_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_hreadyout = ready_r;
	assign o_hresp     = 1'b0;
	assign o_hrdata    = hrdata_r;
	assign o_irq       = |(ev_r & mask_r);

	// byte address of the word, shifted into the product-data window
	assign o_ee.req   = busy_r;
	assign o_ee.we    = (pd_op_r == LPV_OP_WRITE);
	assign o_ee.addr  = {pd_addr_r, 2'h0} + LPV_EE_BASE;
	assign o_ee.wdata = pd_data_r;

	// tuning fields go out untouched
	assign o_phy.cfg0 = cfg0_r;
	assign o_phy.cfg1 = cfg1_r;
	assign o_phy.cfg2 = cfg2_r[23:0];
endmodule
`default_nettype wire

// ### lpv_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lpv_regs_checker (
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	input wire logic                 i_hsel,
	input wire logic [1:0]           i_htrans,
	input wire logic                 i_hwrite,
	input wire logic                 i_hready,
	input wire logic                 o_hreadyout,
	input wire logic                 o_hresp,
	input wire lpv_pkg::lpv_phy_s    o_phy,
	input wire lpv_pkg::lpv_ee_req_s o_ee,
	input wire lpv_pkg::lpv_ee_rsp_s i_ee
);
	import lpv_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// --------
	// bus, phy output and eeprom cycle checks
	// --------
	logic wr_take;
	// accepted write address phase
	assign wr_take = i_hsel & i_htrans[1] & i_hready & i_hwrite;
	sequence s_rd;
		i_hsel && i_htrans[1] && i_hready && !i_hwrite;
	endsequence
	sequence s_rd_wait;
		!o_hreadyout ##1 o_hreadyout;
	endsequence
	a_read_wait: assert property (s_rd |=> s_rd_wait)
		else $error("read wait wrong");
	a_write_fast: assert property (wr_take |=> o_hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (o_hresp == 1'b0)
		else $error("error response");
	a_phy_static: assert property ($changed(o_phy) |-> $past(wr_take, 2))
		else $error("phy changed without write");
	a_phy_reset: assert property ($rose(i_rst_n) |->
		o_phy.cfg2[7:0] == 8'h54 && o_phy.cfg2[23]) else $error("phy reset value");
	a_ee_hold: assert property (o_ee.req && !i_ee.done |=>
		o_ee.req && $stable(o_ee.addr)) else $error("cycle dropped");
	a_ee_end: assert property (o_ee.req && i_ee.done |=> !o_ee.req)
		else $error("cycle not ended");
	a_ee_stands: assert property (o_ee.req && !i_ee.done |=>
		$stable(o_ee.we) && $stable(o_ee.wdata)) else $error("cycle request moved");
endmodule
bind lpv_regs lpv_regs_checker u_chk (.i_clk, .i_rst_n, .i_hsel, .i_htrans, .i_hwrite,
	.i_hready, .o_hreadyout, .o_hresp, .o_phy, .o_ee, .i_ee);
`default_nettype wire

// ### lpv_ee_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpv_ee_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_slow,
	input  wire lpv_pkg::lpv_ee_req_s i_req,
	output var lpv_pkg::lpv_ee_rsp_s  o_rsp
);
	import lpv_pkg::*;
	logic [31:0] mem [64];
	logic [4:0]  cnt = 5'h0;
	logic [31:0] last = 32'h0;
	logic [5:0]  idx;
	// word index from the byte address
	assign idx = i_req.addr[7:2];
	initial o_rsp = '0;
	// one done pulse per cycle, after a short or a long wait
	always @(posedge i_clk) begin
		o_rsp.done <= 1'b0;
		o_rsp.rdata <= ~last; // not valid outside done
		cnt <= (i_req.req && !o_rsp.done) ? cnt + 5'h1 : 5'h0;
		if (i_req.req && !o_rsp.done && cnt >= (i_slow ? 5'h14 : 5'h0)) begin
			o_rsp.done <= 1'b1;
			o_rsp.rdata <= mem[idx];
			last <= mem[idx];
			if (i_req.we)
				mem[idx] <= i_req.wdata;
		end
	end
endmodule
`default_nettype wire

// ### test_link_status_phy_tuning_vpd_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch at %0t: %h vs %h", $time, g, e); end end
module test_link_status_phy_tuning_vpd_regs;
	import lpv_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  haddr = 8'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	lpv_link_s   link = {4'h1, 6'h01, 3'b001};
	logic        hready, hresp, irq;
	logic [31:0] hrdata, r;
	lpv_phy_s    phy;
	lpv_ee_req_s ee;
	lpv_ee_rsp_s rsp;
	int          err_count = 0;
	int          samples_checked = 0;
	// --------
	// design and eeprom
	// --------
	lpv_regs dut (.i_clk, .i_rst_n, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_link(link),
		.o_phy(phy), .o_ee(ee), .i_ee(rsp), .o_irq(irq));
	lpv_ee_model u_ee (.i_clk, .i_slow(slow), .i_req(ee), .o_rsp(rsp));
	// 250 mhz clock
	initial forever #2 i_clk = ~i_clk;
	// --------
	// bus tasks
	// --------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge i_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, r);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, r);
		`CHK(r, e)
	endtask
	task automatic wait_flag(input logic f);
		do xfer(1'b0, LPV_OFS_PD_CTRL, 32'h0, r); while (r[31] !== f);
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_regs;
		chk(LPV_OFS_PHY_CFG0, 32'h0400_1060);
		chk(LPV_OFS_PHY_CFG1, 32'h0400_0800);
		chk(LPV_OFS_PHY_CFG2, 32'h0099_8254);
		chk(LPV_OFS_PD_CTRL, 32'h0000_f003);
		chk(LPV_OFS_LINK_STATUS, 32'h3011_0000);
		link <= {4'h1, 6'h04, 3'b110};
		chk(LPV_OFS_LINK_STATUS, 32'h1c41_0000);
		$display("test regs done");
	endtask
	task automatic t_phy;
		bw(LPV_OFS_PHY_CFG1, 32'h89ab_cdef);
		bw(LPV_OFS_PHY_CFG2, 32'hffff_ffff);
		bw(8'he0, 32'hffff_ffff);
		`CHK(phy, {32'h0400_1060, 32'h89ab_cdef, 24'hff_ffff})
		chk(LPV_OFS_PHY_CFG2, 32'h00ff_ffff);
		chk(8'he0, 32'h0);
		$display("test phy done");
	endtask
	task automatic t_vpd;
		bw(LPV_OFS_PD_DATA, 32'h1234_5678);
		bw(LPV_OFS_PD_CTRL, 32'hff17_ffff);
		@(posedge i_clk);
		`CHK({ee.req, ee.we, ee.addr, ee.wdata}, {10'h354, 32'h1234_5678})
		wait_flag(1'b0);
		`CHK(r, 32'h0014_f003)
		chk(LPV_OFS_IRQ_STAT, 32'h2);
		`CHK(irq, 1'b0)
		bw(LPV_OFS_IRQ_MASK, 32'h3);
		bw(LPV_OFS_PD_DATA, 32'hdead_beef);
		`CHK(irq, 1'b1)
		slow <= 1'b1;
		bw(LPV_OFS_IRQ_STAT, 32'h2);
		bw(LPV_OFS_PD_CTRL, 32'h0014_0000);
		`CHK(irq, 1'b0)
		chk(LPV_OFS_PD_CTRL, 32'h0014_f003);
		bw(LPV_OFS_PD_CTRL, 32'h80fc_0000);
		chk(LPV_OFS_PD_CTRL, 32'h0014_f003);
		wait_flag(1'b1);
		chk(LPV_OFS_PD_DATA, 32'h1234_5678);
		chk(LPV_OFS_IRQ_STAT, 32'h1);
		`CHK(irq, 1'b1)
		$display("test vpd done");
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		t_regs;
		t_phy;
		t_vpd;
		give_verdict;
	end
	// watchdog against a hung handshake
	initial begin
		#20000;
		err_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
